// >>> asc_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the
//   converter sequencer control block.
// Assumes: 20 MHz pclk, APB with 32-bit data, byte addresses.
// Notes: result words sit at ASC_RES_BASE + 4*n; byte views at ASC_RESH_BASE.
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// register byte offsets
`define ASC_MODE0_OFS 8'h00
`define ASC_MODE2_OFS 8'h04
`define ASC_CHSEL_OFS 8'h08
`define ASC_CMPM_OFS 8'h0c
`define ASC_THR_OFS 8'h10
`define ASC_RES_BASE 8'h40
`define ASC_RESH_BASE 8'h80
// mode 0 fields
`define ASC_M0_ENABLE 7
`define ASC_M0_OPMODE_HI 6
`define ASC_M0_OPMODE_LO 5
`define ASC_M0_EDGE_HI 4
`define ASC_M0_EDGE_LO 3
`define ASC_M0_HWTRIG 2
`define ASC_M0_ACTIVE 0
// compare mode fields
`define ASC_CMP_ENABLE 7
`define ASC_CMP_DIR 6
// reset values
`define ASC_REG_RESET 8'h00
`define ASC_RES_RESET 10'h000
// timing: sampling interval in ns and its cycle count (rounded up)
`define ASC_CLK_NS 50
`define ASC_SAMPLE_NS 800
`define ASC_SAMPLE_CYC ((`ASC_SAMPLE_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)

`endif

// >>> asc_pkg.sv
// Purpose: types shared by the converter sequencer control block.
// Assumes: constants live in asc_consts.svh.
// Notes: enums carry no explicit codes except where software sees them.
`default_nettype none

package asc_pkg;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } asc_apb_req_type;

  // operation mode field as software writes it
  typedef enum logic [1:0] {
    ASC_CONT_SELECT = 2'h0,
    ASC_CONT_SCAN = 2'h1,
    ASC_ONESHOT_A = 2'h2,
    ASC_ONESHOT_SCAN = 2'h3
  } asc_opmode_type;

  typedef enum logic [1:0] {
    ASC_TRIG_PIN = 2'h0,
    ASC_TRIG_TMR0 = 2'h1,
    ASC_TRIG_TMR1 = 2'h2,
    ASC_TRIG_BAD = 2'h3
  } asc_hwtrig_type;

  typedef enum {
    ASC_IDLE,
    ASC_WAIT,
    ASC_SAMPLE,
    ASC_CONV
  } asc_state_type;

endpackage

`default_nettype wire

// >>> asc_top.sv
// Purpose: successive-approximation sequencer with triggers, scan modes,
//   threshold-gated conversion-end pulse and an APB register file.
// Assumes: comparator_high is synchronous to pclk and settles in one cycle.
// Notes: prdata is captured in the setup phase, so pready is always high.
`include "asc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module asc_top #(
  parameter int SAMPLE_CYC = `ASC_SAMPLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire asc_pkg::asc_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_trigger_pin,
  input wire logic timer_match_event_0,
  input wire logic timer_match_event_1,
  input wire logic comparator_high,
  output logic [3:0] channel_mux,
  output logic sample_enable,
  output logic [9:0] dac_level,
  output logic conversion_end_irq
);

  // register decode for pslverr, applied to reads and writes alike
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `ASC_MODE0_OFS) || (a == `ASC_MODE2_OFS) ||
      (a == `ASC_CHSEL_OFS) || (a == `ASC_CMPM_OFS) || (a == `ASC_THR_OFS) ||
      (a[7:6] == 2'h1 && a[1:0] == 2'h0) || (a[7:6] == 2'h2 && a[1:0] == 2'h0);
  endfunction

  logic [7:0] mode0_q;
  logic [1:0] mode2_q;
  logic [3:0] chsel_q;
  logic [1:0] cmpm_q;
  logic [7:0] thr_q;
  logic [9:0] res_q [16];
  asc_pkg::asc_state_type state_q;
  logic [3:0] ch_q;
  logic [9:0] sar_q;
  logic [9:0] trial_q;
  logic [7:0] samp_cnt_q;
  logic finish_then_wait_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic tmr0_prev_q;
  logic tmr1_prev_q;

  logic wr_acc;
  logic cfg_wr;
  logic enable;
  logic hw_mode;
  logic scan_mode;
  logic oneshot;
  logic active;
  logic trig;
  logic pin_rise;
  logic pin_fall;
  logic [1:0] edge_sel;
  logic last_bit;
  logic [9:0] sar_done;
  logic last_ch;
  logic [7:0] cmp_byte;
  logic cmp_pass;
  logic wr_en_set;
  logic wr_en_clr;
  logic start;
  logic [3:0] first_ch;
  logic [7:0] mode0_nx;
  logic [3:0] chsel_nx;

  // access phase write, and writes that count as reconfiguration
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign cfg_wr = wr_acc & ((apb_req.paddr == `ASC_MODE0_OFS) |
    (apb_req.paddr == `ASC_MODE2_OFS) | (apb_req.paddr == `ASC_CHSEL_OFS) |
    (apb_req.paddr == `ASC_CMPM_OFS) | (apb_req.paddr == `ASC_THR_OFS));
  assign wr_en_set = wr_acc & (apb_req.paddr == `ASC_MODE0_OFS) &
    apb_req.pwdata[`ASC_M0_ENABLE] & ~mode0_q[`ASC_M0_ENABLE];
  assign wr_en_clr = wr_acc & (apb_req.paddr == `ASC_MODE0_OFS) &
    ~apb_req.pwdata[`ASC_M0_ENABLE];

  assign enable = mode0_q[`ASC_M0_ENABLE];
  assign hw_mode = mode0_q[`ASC_M0_HWTRIG];
  assign scan_mode = mode0_q[`ASC_M0_OPMODE_LO];
  assign oneshot = mode0_q[`ASC_M0_OPMODE_HI];
  assign edge_sel = {mode0_q[`ASC_M0_EDGE_HI], mode0_q[`ASC_M0_EDGE_LO]};
  assign active = (state_q == asc_pkg::ASC_SAMPLE) | (state_q == asc_pkg::ASC_CONV);
  // a start or restart caused by a write must see the value being written,
  // not the one it replaces, or a first enable would use the old mode
  assign mode0_nx = (wr_acc && apb_req.paddr == `ASC_MODE0_OFS) ? apb_req.pwdata[7:0] :
    mode0_q;
  assign chsel_nx = (wr_acc && apb_req.paddr == `ASC_CHSEL_OFS) ? apb_req.pwdata[3:0] :
    chsel_q;
  assign first_ch = mode0_nx[`ASC_M0_OPMODE_LO] ? 4'h0 : chsel_nx;

  // software-visible configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode0_q <= `ASC_REG_RESET;
      mode2_q <= 2'h0;
      chsel_q <= 4'h0;
      cmpm_q <= 2'h0;
      thr_q <= `ASC_REG_RESET;
    end
    else if (wr_acc)
    begin
      case (apb_req.paddr)
        `ASC_MODE0_OFS: mode0_q <= {apb_req.pwdata[7:1], 1'b0};
        `ASC_MODE2_OFS: mode2_q <= apb_req.pwdata[1:0];
        `ASC_CHSEL_OFS: mode0_q <= mode0_q;
        `ASC_CMPM_OFS: cmpm_q <= apb_req.pwdata[7:6];
        `ASC_THR_OFS: thr_q <= apb_req.pwdata[7:0];
        default: mode0_q <= mode0_q;
      endcase
      if (apb_req.paddr == `ASC_CHSEL_OFS)
      begin
        chsel_q <= apb_req.pwdata[3:0];
      end
    end
  end

  // read data is fetched in the setup phase so the access phase never waits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (apb_req.psel & ~apb_req.penable)
    begin
      prdata_q <= 32'h0000_0000;
      case (apb_req.paddr)
        `ASC_MODE0_OFS: prdata_q <= {24'h00_0000, mode0_q[7:1], active};
        `ASC_MODE2_OFS: prdata_q <= {30'h0000_0000, mode2_q};
        `ASC_CHSEL_OFS: prdata_q <= {28'h000_0000, chsel_q};
        `ASC_CMPM_OFS: prdata_q <= {24'h00_0000, cmpm_q, 6'h00};
        `ASC_THR_OFS: prdata_q <= {24'h00_0000, thr_q};
        default:
        begin
          if (apb_req.paddr[7:6] == 2'h1)
          begin
            prdata_q <= {16'h0000, res_q[apb_req.paddr[5:2]], 6'h00};
          end
          else if (apb_req.paddr[7:6] == 2'h2)
          begin
            prdata_q <= {24'h00_0000, res_q[apb_req.paddr[5:2]][9:2]};
          end
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = apb_req.psel & apb_req.penable & ~addr_known(apb_req.paddr);

  // trigger pin passes two flops before edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
      tmr0_prev_q <= 1'b0;
      tmr1_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= external_trigger_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      tmr0_prev_q <= timer_match_event_0;
      tmr1_prev_q <= timer_match_event_1;
    end
  end

  // edge select: 00 falling, 01 rising, 1x both
  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign pin_fall = ~pin_sync_q & pin_prev_q;
  always_comb
  begin
    trig = 1'b0;
    case (asc_pkg::asc_hwtrig_type'(mode2_q))
      asc_pkg::ASC_TRIG_PIN:
        trig = (edge_sel == 2'h1) ? pin_rise :
          (edge_sel == 2'h0) ? pin_fall : (pin_rise | pin_fall);
      asc_pkg::ASC_TRIG_TMR0: trig = timer_match_event_0 & ~tmr0_prev_q;
      asc_pkg::ASC_TRIG_TMR1: trig = timer_match_event_1 & ~tmr1_prev_q;
      default: trig = 1'b0; // prohibited setting never triggers
    endcase
    trig = trig & enable & hw_mode;
  end

  // completion of the tenth trial and the compare decision
  assign last_bit = trial_q[0];
  assign sar_done = comparator_high ? sar_q : (sar_q & ~trial_q);
  assign last_ch = scan_mode ? (ch_q == chsel_q) : 1'b1;
  assign cmp_byte = (scan_mode && ch_q != 4'h0) ? res_q[0][9:2] : sar_done[9:2];
  assign cmp_pass = ~cmpm_q[1] |
    (cmpm_q[0] ? (cmp_byte < thr_q) : (cmp_byte >= thr_q));
  assign start = (~mode0_nx[`ASC_M0_HWTRIG] & wr_en_set) | trig;

  // sequencer: idle, await trigger, sample, ten trials
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= asc_pkg::ASC_IDLE;
      ch_q <= 4'h0;
      sar_q <= 10'h000;
      trial_q <= 10'h000;
      samp_cnt_q <= 8'h00;
      finish_then_wait_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= 1'b0;
      if (wr_en_clr)
      begin
        state_q <= asc_pkg::ASC_IDLE;
        finish_then_wait_q <= 1'b0;
      end
      else if (start || (~hw_mode && cfg_wr && active))
      begin
        // fresh start or restart from the beginning
        state_q <= asc_pkg::ASC_SAMPLE;
        ch_q <= first_ch;
        samp_cnt_q <= 8'(SAMPLE_CYC - 1);
        finish_then_wait_q <= 1'b0;
      end
      else if (wr_en_set)
      begin
        state_q <= asc_pkg::ASC_WAIT;
      end
      else if (hw_mode && cfg_wr && active && mode2_q != 2'h0)
      begin
        state_q <= asc_pkg::ASC_WAIT;
      end
      else
      begin
        if (hw_mode && cfg_wr && active)
        begin
          finish_then_wait_q <= 1'b1;
        end
        case (state_q)
          asc_pkg::ASC_SAMPLE:
          begin
            // input tracked until the count ends, held afterwards
            if (samp_cnt_q == 8'h00)
            begin
              state_q <= asc_pkg::ASC_CONV;
              sar_q <= 10'h200;
              trial_q <= 10'h200;
            end
            else
            begin
              samp_cnt_q <= samp_cnt_q - 8'h01;
            end
          end
          asc_pkg::ASC_CONV:
          begin
            if (!last_bit)
            begin
              sar_q <= sar_done | (trial_q >> 1);
              trial_q <= trial_q >> 1;
            end
            else
            begin
              // all ten bits resolved: result kept, pulse gated
              irq_q <= last_ch & cmp_pass;
              samp_cnt_q <= 8'(SAMPLE_CYC - 1);
              trial_q <= 10'h000;
              finish_then_wait_q <= 1'b0;
              if (finish_then_wait_q)
              begin
                state_q <= asc_pkg::ASC_WAIT;
              end
              else if (!last_ch)
              begin
                state_q <= asc_pkg::ASC_SAMPLE;
                ch_q <= ch_q + 4'h1;
              end
              else if (hw_mode)
              begin
                state_q <= asc_pkg::ASC_WAIT;
              end
              else if (oneshot)
              begin
                state_q <= asc_pkg::ASC_IDLE;
              end
              else
              begin
                state_q <= asc_pkg::ASC_SAMPLE;
                ch_q <= first_ch;
              end
            end
          end
          asc_pkg::ASC_WAIT: state_q <= asc_pkg::ASC_WAIT;
          asc_pkg::ASC_IDLE: state_q <= asc_pkg::ASC_IDLE;
          default: state_q <= asc_pkg::ASC_IDLE;
        endcase
      end
    end
  end

  // result store on the last trial, whatever the compare says
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        res_q[i] <= `ASC_RES_RESET;
      end
    end
    else if (state_q == asc_pkg::ASC_CONV && last_bit && !wr_en_clr && !start &&
      !(cfg_wr && (!hw_mode || mode2_q != 2'h0)))
    begin
      res_q[ch_q] <= sar_done;
    end
  end

  assign channel_mux = ch_q;
  assign sample_enable = (state_q == asc_pkg::ASC_SAMPLE);
  assign dac_level = sar_q;
  assign conversion_end_irq = irq_q;

endmodule

`default_nettype wire

// >>> asc_analog_model.sv
// Purpose: analog side of the sequencer: channel levels and comparator.
// Assumes: levels are 10-bit codes; comparator is same-clock.
// Notes: tracks while sampling and holds after, as a real sample stage would.
`timescale 1ns/1ps
`default_nettype none
module asc_analog_model (
  input wire logic pclk,
  input wire logic [3:0] channel_mux,
  input wire logic sample_enable,
  input wire logic [9:0] dac_level,
  input wire logic [15:0][9:0] level_tbl,
  output logic comparator_high
);
  logic [9:0] held_q;
  // hold stops later level changes from leaking into the trials
  always_ff @(posedge pclk)
    if (sample_enable) held_q <= level_tbl[channel_mux];
  // input at or above the trial level keeps the bit
  assign comparator_high = (held_q >= dac_level);
endmodule
`default_nettype wire

// >>> asc_top_assertions.sv
// Purpose: port checks of the converter sequencer control block.
// Assumes: registered one-cycle irq, prdata captured at setup.
// Notes: attached to asc_top by bind.
`timescale 1ns/1ps
`default_nettype none
module asc_top_checker #(
  parameter int SAMPLE_CYC = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire asc_pkg::asc_apb_req_type apb_req,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic comparator_high,
  input wire logic [3:0] channel_mux,
  input wire logic sample_enable,
  input wire logic [9:0] dac_level,
  input wire logic conversion_end_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc, mapped;
  // access phase and implemented word map
  assign acc = apb_req.psel && apb_req.penable;
  assign mapped = (apb_req.paddr[1:0] == 2'h0) && ((apb_req.paddr <= 8'h10) ||
    (apb_req.paddr >= 8'h40 && apb_req.paddr < 8'hc0));
  // error flag only for holes in the map
  AST_MAPPED_OK: assert property (acc && mapped |-> !pslverr) else $error("bad pslverr");
  AST_UNMAPPED_ERR: assert property (acc && !mapped && !apb_req.pwrite |->
    pslverr && prdata == 32'h0) else $error("hole not refused");
  // read data stands until the next setup
  AST_PRDATA_HOLD: assert property (!(apb_req.psel && !apb_req.penable) |=>
    $stable(prdata)) else $error("prdata moved");
  AST_RES_WORD: assert property (acc && !apb_req.pwrite && apb_req.paddr[7:6] == 2'h1 |->
    prdata[5:0] == 6'h0 && prdata[31:16] == 16'h0) else $error("result padding");
  // end pulse: one cycle, only after the trials
  AST_IRQ_PULSE: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("irq too long");
  AST_IRQ_AFTER_CONV: assert property (conversion_end_irq |->
    !$past(sample_enable, 2) && !$past(sample_enable, 9)) else $error("irq early");
  AST_FIRST_TRIAL: assert property (!sample_enable && dac_level == 10'h200 ##1
    !sample_enable && dac_level[8] && dac_level[7:0] == 8'h0 |->
    dac_level[9] == $past(comparator_high)) else $error("msb decision");
  AST_MUX_HOLD: assert property ($fell(sample_enable) ##1 !sample_enable [*8] |->
    channel_mux == $past(channel_mux, 8)) else $error("channel moved");
  // main scenarios reached
  cover property (conversion_end_irq);
  cover property (acc && pslverr);
  cover property ($fell(sample_enable));
endmodule
bind asc_top asc_top_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pslverr(pslverr),
  .comparator_high(comparator_high), .channel_mux(channel_mux),
  .sample_enable(sample_enable), .dac_level(dac_level),
  .conversion_end_irq(conversion_end_irq));
`default_nettype wire

// >>> adc_sequencer_control_tb_top.sv
// Purpose: self-checking bench of the converter sequencer control block.
// Assumes: SAMPLE_CYC cut to 2; levels from asc_analog_model.
// Notes: a finished result equals the channel level code.
`include "asc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module adc_sequencer_control_tb_top;
  localparam int SC = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  asc_pkg::asc_apb_req_type apb_req = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cmp_hi, samp, irq;
  logic [3:0] mux, ch;
  logic [9:0] dac;
  logic [2:0] trg = 3'h0;
  logic [15:0][9:0] lvl = '0;
  logic [31:0] seed = 32'hce269df4;
  int n_errors = 0, check_count = 0, n_irq = 0, cyc = 0;
  asc_top #(.SAMPLE_CYC(SC)) uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_trigger_pin(trg[0]),
    .timer_match_event_0(trg[1]), .timer_match_event_1(trg[2]), .comparator_high(cmp_hi),
    .channel_mux(mux), .sample_enable(samp), .dac_level(dac), .conversion_end_irq(irq));
  asc_analog_model u_ana (.pclk(pclk), .channel_mux(mux), .sample_enable(samp),
    .dac_level(dac), .level_tbl(lvl), .comparator_high(cmp_hi));
  // clock, pulse tally, hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (irq === 1'b1) n_irq++;
    if (cyc == 30000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // whether a pass should end with the pulse
  function automatic int want(input logic en, input logic dir, input logic [7:0] hb,
    input logic [7:0] thr);
    return int'(!en || (dir ? hb < thr : hb >= thr));
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; a spare edge after release keeps drivers apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask
  initial
  begin
    int base;
    logic [7:0] thr;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK("reset", 32'h0, rd)
    end
    seed = nxt(seed);
    apb(1'b1, `ASC_THR_OFS, {24'h0, seed[7:0]});
    apb(1'b0, `ASC_THR_OFS, 32'h0);
    `CHK("thr", {24'h0, seed[7:0]}, rd)
    apb(1'b0, 8'hfc, 32'h0);
    `CHK("slverr", 1'b1, err)
    // one-shot scans: compare off, both senses, equal boundary, restart by write
    for (int k = 0; k < 6; k++)
    begin
      for (int i = 0; i < 16; i++)
      begin
        seed = nxt(seed);
        lvl[i] = seed[9:0];
      end
      ch = seed[13:10];
      thr = (k > 3) ? lvl[0][9:2] : seed[23:16];
      apb(1'b1, `ASC_CHSEL_OFS, {28'h0, ch});
      apb(1'b1, `ASC_THR_OFS, {24'h0, thr});
      apb(1'b1, `ASC_CMPM_OFS, {24'h0, k > 0, k[0], 6'h0});
      base = n_irq;
      apb(1'b1, `ASC_MODE0_OFS, 32'he0);
      if (k == 2) apb(1'b1, `ASC_THR_OFS, {24'h0, thr});
      repeat ((ch + 1) * (SC + 14) + 20) @(posedge pclk);
      `CHK("scan irq", want(k > 0, k[0], lvl[0][9:2], thr), n_irq - base)
      for (int i = 0; i <= ch; i++)
      begin
        apb(1'b0, `ASC_RES_BASE + 8'(4 * i), 32'h0);
        `CHK("result", {16'h0, lvl[i], 6'h0}, rd)
      end
      apb(1'b0, `ASC_RESH_BASE, 32'h0);
      `CHK("byte view", {24'h0, lvl[0][9:2]}, rd)
      apb(1'b1, `ASC_MODE0_OFS, 32'h0);
    end
    // continuous select repeats until enable clears
    apb(1'b1, `ASC_CMPM_OFS, 32'h0);
    base = n_irq;
    apb(1'b1, `ASC_MODE0_OFS, 32'h80);
    apb(1'b0, `ASC_MODE0_OFS, 32'h0);
    `CHK("active", 1'b1, rd[0])
    repeat (4 * (SC + 14)) @(posedge pclk);
    `CHK("repeats", 1'b1, n_irq - base >= 3)
    apb(1'b1, `ASC_MODE0_OFS, 32'h0);
    apb(1'b0, `ASC_RES_BASE + 8'(4 * ch), 32'h0);
    `CHK("select result", {16'h0, lvl[ch], 6'h0}, rd)
    // hardware triggers: pin rising edge only, timer events 0 and 1
    for (int t = 0; t < 3; t++)
    begin
      apb(1'b1, `ASC_MODE2_OFS, 32'(t));
      apb(1'b1, `ASC_MODE0_OFS, 32'h8c);
      base = n_irq;
      repeat (30) @(posedge pclk);
      apb(1'b0, `ASC_MODE0_OFS, 32'h0);
      `CHK("waiting", 32'h8c, rd)
      trg[t] <= 1'b1;
      repeat (30) @(posedge pclk);
      trg[t] <= 1'b0;
      repeat (30) @(posedge pclk);
      `CHK("hw irq", 1, n_irq - base)
    end
    // timer mode: a register write mid-conversion drops it
    apb(1'b1, `ASC_MODE2_OFS, 32'h1);
    apb(1'b1, `ASC_MODE0_OFS, 32'h84);
    base = n_irq;
    trg[1] <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, `ASC_THR_OFS, 32'h0);
    repeat (40) @(posedge pclk);
    `CHK("stopped", 0, n_irq - base)
    print_verdict();
  end
endmodule
`default_nettype wire
